// >>> core/swc_pkg.sv
// Shared constants and types for the sleep and wake-up controller
package swc_pkg;
  localparam int SRC_W_DEFAULT = 16;
  localparam int GROUP0_W_DEFAULT = 8;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_AWAKE = 2'h2;
  localparam logic [1:0] BOR_SOFT = 2'h1;
  localparam logic [1:0] BOR_OFF = 2'h0;
  localparam logic RST_TIMEOUT_FLAG = 1'b1;
  localparam logic RST_POWERDOWN_FLAG = 1'b1;
  localparam int EVT_W = 3;
  localparam int EVT_RESET_WAKE = 0;
  localparam int EVT_INT_WAKE = 1;
  localparam int EVT_SLEEP_NOP = 2;
  localparam logic [EVT_W-1:0] RST_MASK = 3'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_READY_WAIT
  } swc_state_type;
endpackage

// >>> core/swc_top.sv
// Sleep and wake-up control for the processor core
//
// Contract
// - Leave sleep on enabled reset sources or interrupts
// - Reset-class wake resets; interrupt wake continues
// - Sleep prefetches instruction at address plus two
// - Wake needs own enable; others need peripheral enable
// - Interrupt wake ignores global interrupt enable
// - Global enable clear: resume after sleep, no vector
// - Global enable set: next instruction, then vector
// - Watchdog cleared on every wake
// - Wait flash, oscillator, brown-out ready before running
// - Pending rule: global clear, enabled flagged source
// - Pending before sleep: sleep acts as no-op
// - Pending during sleep: complete, wake, set flags
// - Powerdown flag set after sleep means no-op
// - Decode two-bit brown-out enable field
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module swc_top #(
  parameter int SRC_W = swc_pkg::SRC_W_DEFAULT,
  parameter int GROUP0_W = swc_pkg::GROUP0_W_DEFAULT,
  parameter int PC_W = 21
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sleep_exec,
  input wire logic [PC_W-1:0] sleep_pc,
  input wire logic [SRC_W-1:0] int_flag,
  input wire logic [SRC_W-1:0] int_enable,
  input wire logic [SRC_W-1:0] clock_switch_sel,
  input wire logic global_interrupt_enable,
  input wire logic peripheral_interrupt_enable,
  input wire logic master_clear_pin,
  input wire logic master_clear_enable,
  input wire logic brownout_reset,
  input wire logic low_power_brownout_reset,
  input wire logic low_power_brownout_enable,
  input wire logic power_on_reset,
  input wire logic watchdog_timer_event,
  input wire logic watchdog_enable,
  input wire logic [1:0] brownout_enable_field,
  input wire logic software_brownout_enable,
  input wire logic program_flash_memory_ready,
  input wire logic current_osc_select_ready,
  input wire logic brownout_ready,
  input wire logic flag_clear,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic core_clk_en,
  output logic [PC_W-1:0] prefetch_pc,
  output logic prefetch_valid,
  output logic device_reset_req,
  output logic resume_exec,
  output logic vector_after_next,
  output logic watchdog_clear,
  output logic brownout_active,
  output logic timeout_flag,
  output logic powerdown_flag
);
  // The address step is cut from a 32-bit constant, so wider counters are refused
  if (SRC_W < 1 || GROUP0_W < 0 || GROUP0_W > SRC_W || PC_W < 2 || PC_W > 32) begin : g_bad_param
    $error("swc_top: unsupported parameter values");
  end

  swc_pkg::swc_state_type state;
  logic [SRC_W-1:0] wake_qual;
  logic [SRC_W-1:0] periph_sel;
  logic int_wake;
  logic reset_wake;
  logic pending;
  logic bor_needed;
  logic all_ready;
  logic asleep;
  logic [swc_pkg::EVT_W-1:0] status;
  logic [swc_pkg::EVT_W-1:0] mask;
  logic [swc_pkg::EVT_W-1:0] evt;
  logic gie_at_wake;

  // Sources beyond the first flag group also need the peripheral enable
  always_comb begin
    periph_sel = '0;
    for (int i = 0; i < SRC_W; i++) begin
      periph_sel[i] = (i >= GROUP0_W);
    end
  end

  // Global enable is not looked at, so wake works with it clear
  assign wake_qual = int_flag & int_enable & ~clock_switch_sel
                     & (~periph_sel | {SRC_W{peripheral_interrupt_enable}});
  assign int_wake = |wake_qual;
  assign pending = int_wake & ~global_interrupt_enable;
  assign reset_wake = (master_clear_pin & master_clear_enable) | brownout_reset
                      | (low_power_brownout_reset & low_power_brownout_enable)
                      | power_on_reset | (watchdog_timer_event & watchdog_enable);
  assign asleep = (state == swc_pkg::SWC_SLEEP);

  always_comb begin
    case (brownout_enable_field)
      swc_pkg::BOR_ALWAYS: bor_needed = 1'b1;
      swc_pkg::BOR_AWAKE: bor_needed = ~asleep;
      swc_pkg::BOR_SOFT: bor_needed = software_brownout_enable;
      default: bor_needed = 1'b0;
    endcase
  end
  assign brownout_active = bor_needed;

  // Brown-out readiness only gates the restart when brown-out will be on once running
  assign all_ready = program_flash_memory_ready & current_osc_select_ready
                     & (brownout_ready | (brownout_enable_field == swc_pkg::BOR_OFF)
                        | (brownout_enable_field == swc_pkg::BOR_SOFT
                           & ~software_brownout_enable));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= swc_pkg::SWC_RUN;
    end else if (clk_en) begin
      case (state)
        swc_pkg::SWC_RUN: begin
          if (sleep_exec && !pending && !reset_wake) begin
            state <= swc_pkg::SWC_SLEEP;
          end
        end
        swc_pkg::SWC_SLEEP: begin
          if (reset_wake) begin
            state <= swc_pkg::SWC_RUN;
          end else if (int_wake) begin
            state <= swc_pkg::SWC_READY_WAIT;
          end
        end
        swc_pkg::SWC_READY_WAIT: begin
          if (reset_wake) begin
            state <= swc_pkg::SWC_RUN;
          end else if (all_ready) begin
            state <= swc_pkg::SWC_RUN;
          end
        end
        default: state <= swc_pkg::SWC_RUN;
      endcase
    end
  end

  // Held low for sleep and the readiness wait; registers simply freeze
  assign core_clk_en = (state == swc_pkg::SWC_RUN);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prefetch_pc <= '0;
      prefetch_valid <= 1'b0;
    end else if (clk_en) begin
      prefetch_valid <= sleep_exec && state == swc_pkg::SWC_RUN;
      if (sleep_exec && state == swc_pkg::SWC_RUN) begin
        prefetch_pc <= sleep_pc + swc_pkg::PC_STEP[PC_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      device_reset_req <= 1'b0;
      watchdog_clear <= 1'b0;
      resume_exec <= 1'b0;
      vector_after_next <= 1'b0;
      gie_at_wake <= 1'b0;
    end else if (clk_en) begin
      device_reset_req <= (asleep || state == swc_pkg::SWC_READY_WAIT) && reset_wake;
      // Entering sleep clears too: sleep that completes restarts the watchdog
      watchdog_clear <= (asleep && (reset_wake || int_wake))
                        || (state == swc_pkg::SWC_RUN && sleep_exec && !pending
                            && !reset_wake);
      if (asleep && int_wake) begin
        gie_at_wake <= global_interrupt_enable;
      end
      resume_exec <= state == swc_pkg::SWC_READY_WAIT && all_ready && !reset_wake;
      vector_after_next <= state == swc_pkg::SWC_READY_WAIT && all_ready && !reset_wake
                           && gie_at_wake;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timeout_flag <= swc_pkg::RST_TIMEOUT_FLAG;
      powerdown_flag <= swc_pkg::RST_POWERDOWN_FLAG;
    end else if (clk_en) begin
      if (state == swc_pkg::SWC_RUN && sleep_exec && !pending && !reset_wake) begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b0;
      end else if (flag_clear) begin
        timeout_flag <= swc_pkg::RST_TIMEOUT_FLAG;
        powerdown_flag <= swc_pkg::RST_POWERDOWN_FLAG;
      end
    end
  end

  assign evt[swc_pkg::EVT_RESET_WAKE] = device_reset_req;
  assign evt[swc_pkg::EVT_INT_WAKE] = resume_exec;
  assign evt[swc_pkg::EVT_SLEEP_NOP] = prefetch_valid & powerdown_flag;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= '0;
    end else if (clk_en) begin
      // New events win over a simultaneous write-one clear
      if (reg_write && reg_addr == swc_pkg::ADDR_STATUS) begin
        status <= (status & ~reg_wdata[swc_pkg::EVT_W-1:0]) | evt;
      end else begin
        status <= status | evt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask <= swc_pkg::RST_MASK;
    end else if (clk_en && reg_write && reg_addr == swc_pkg::ADDR_MASK) begin
      mask <= reg_wdata[swc_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_read) begin
        case (reg_addr)
          swc_pkg::ADDR_STATUS: reg_rdata <= {5'h00, status};
          swc_pkg::ADDR_MASK: reg_rdata <= {5'h00, mask};
          swc_pkg::ADDR_FLAGS: reg_rdata <= {6'h00, timeout_flag, powerdown_flag};
          swc_pkg::ADDR_STATE: reg_rdata <= {6'h00, state};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign irq = |(status & mask);

  property p_nop_stays_awake;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_RUN && sleep_exec && pending && !reset_wake
       && !flag_clear)
      |=> state == swc_pkg::SWC_RUN && $stable(powerdown_flag) && !watchdog_clear;
  endproperty
  a_nop_stays_awake: assert property (p_nop_stays_awake)
    else $error("pending interrupt did not turn sleep into a no-op");

  property p_sleep_flags;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_RUN && sleep_exec && !pending && !reset_wake)
      |=> asleep && timeout_flag && !powerdown_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep entry flags wrong");

  property p_int_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && asleep && int_wake && !reset_wake)
      |=> state == swc_pkg::SWC_READY_WAIT && watchdog_clear && !device_reset_req;
  endproperty
  a_int_wake: assert property (p_int_wake)
    else $error("interrupt wake not taken");

  property p_reset_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && asleep && reset_wake) |=> device_reset_req && watchdog_clear;
  endproperty
  a_reset_wake: assert property (p_reset_wake)
    else $error("reset-class wake did not request reset");

  property p_ready_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_READY_WAIT && !reset_wake && !program_flash_memory_ready)
      |=> state == swc_pkg::SWC_READY_WAIT && !resume_exec;
  endproperty
  a_ready_gate: assert property (p_ready_gate)
    else $error("resumed before flash ready");

  property p_vector;
    @(posedge ref_clk) disable iff (!rst_n)
      vector_after_next |-> resume_exec && $past(gie_at_wake);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector without global enable at wake");

  property p_prefetch;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_RUN && sleep_exec)
      |=> prefetch_valid && prefetch_pc == $past(sleep_pc) + swc_pkg::PC_STEP[PC_W-1:0];
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("prefetch address wrong");

  property p_clock_stop;
    @(posedge ref_clk) disable iff (!rst_n)
      asleep |-> !core_clk_en;
  endproperty
  a_clock_stop: assert property (p_clock_stop)
    else $error("core clock running in sleep");

  property p_bor_decode;
    @(posedge ref_clk) disable iff (!rst_n)
      (brownout_enable_field == swc_pkg::BOR_AWAKE) |-> brownout_active == !asleep;
  endproperty
  a_bor_decode: assert property (p_bor_decode)
    else $error("brown-out enable decode wrong");

  property p_nop_timeout;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_RUN && sleep_exec && pending && !flag_clear)
      |=> $stable(timeout_flag) && !asleep;
  endproperty
  a_nop_timeout: assert property (p_nop_timeout)
    else $error("pending interrupt changed the timeout flag");

  property p_resume_no_vector;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_READY_WAIT && all_ready && !reset_wake && !gie_at_wake)
      |=> resume_exec && !vector_after_next && core_clk_en;
  endproperty
  a_resume_no_vector: assert property (p_resume_no_vector)
    else $error("vectored although global enable was clear at wake");

  property p_sleep_holds;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && asleep && !int_wake && !reset_wake) |=> asleep && !watchdog_clear;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("left sleep without a wake event");

  property p_bor_ready_skip;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_READY_WAIT && !reset_wake && program_flash_memory_ready
       && current_osc_select_ready && brownout_enable_field == swc_pkg::BOR_OFF)
      |=> resume_exec;
  endproperty
  a_bor_ready_skip: assert property (p_bor_ready_skip)
    else $error("waited for brown-out ready while brown-out is off");

  property p_reset_blocks_sleep;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == swc_pkg::SWC_RUN && sleep_exec && reset_wake && !flag_clear)
      |=> !asleep && !watchdog_clear && $stable(powerdown_flag);
  endproperty
  a_reset_blocks_sleep: assert property (p_reset_blocks_sleep)
    else $error("sleep taken while a reset-class source was active");
endmodule // swc_top

// >>> verif/swc_core_model.sv
// Core-side model: issues sleep instructions and their address
`timescale 1ns/1ps
module swc_core_model #(
  parameter int PC_W = 21
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic core_clk_en,
  input wire logic go,
  input wire logic [PC_W-1:0] pc,
  output logic sleep_exec = 1'b0,
  output logic [PC_W-1:0] sleep_pc = '0
);
  // A halted core issues nothing; the idle address is junk so a stale value cannot pass
  always @(posedge ref_clk) begin
    sleep_exec <= rst_n & go & core_clk_en;
    sleep_pc <= go ? pc : ~pc;
  end
endmodule // swc_core_model

// >>> verif/swc_top_test.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
module swc_top_test;
  localparam int PC_W = 21;
  logic ref_clk, rst_n, clk_en, go, sleep_exec, global_interrupt_enable;
  logic peripheral_interrupt_enable, master_clear_pin, master_clear_enable, brownout_reset;
  logic low_power_brownout_reset, low_power_brownout_enable, power_on_reset;
  logic watchdog_timer_event, watchdog_enable, software_brownout_enable, flag_clear;
  logic program_flash_memory_ready, current_osc_select_ready, brownout_ready;
  logic reg_write, reg_read, irq, core_clk_en, prefetch_valid, device_reset_req, resume_exec;
  logic vector_after_next, watchdog_clear, brownout_active, timeout_flag, powerdown_flag;
  logic [PC_W-1:0] pc, sleep_pc, prefetch_pc;
  logic [15:0] int_flag, int_enable, clock_switch_sel;
  logic [1:0] brownout_enable_field;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int fail_count = 0;
  int checked = 0;
  swc_top u_dut (.ref_clk, .rst_n, .clk_en, .sleep_exec, .sleep_pc, .int_flag, .int_enable,
    .clock_switch_sel, .global_interrupt_enable, .peripheral_interrupt_enable,
    .master_clear_pin, .master_clear_enable, .brownout_reset, .low_power_brownout_reset,
    .low_power_brownout_enable, .power_on_reset, .watchdog_timer_event, .watchdog_enable,
    .brownout_enable_field, .software_brownout_enable, .program_flash_memory_ready,
    .current_osc_select_ready, .brownout_ready, .flag_clear, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .irq, .core_clk_en, .prefetch_pc, .prefetch_valid,
    .device_reset_req, .resume_exec, .vector_after_next, .watchdog_clear, .brownout_active,
    .timeout_flag, .powerdown_flag);
  swc_core_model u_core (.ref_clk, .rst_n, .core_clk_en, .go, .pc, .sleep_exec, .sleep_pc);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_sleep(input logic [PC_W-1:0] a);
    @(posedge ref_clk);
    go <= 1'b1;
    pc <= a;
    @(posedge ref_clk);
    go <= 1'b0;
    step(1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    step(1);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    step(1);
    reg_read <= 1'b0;
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic t_bor_field;
    for (int i = 0; i < 8; i++) begin
      brownout_enable_field <= i[2:1];
      software_brownout_enable <= i[0];
      step(1);
      chk("brownout_active", brownout_active, i[2] || (i[1] && i[0]));
    end
    brownout_enable_field <= 2'h3;
    $display("t_bor_field done");
  endtask
  task automatic t_int_wake(input logic gie_v, input logic [PC_W-1:0] a);
    logic [PC_W-1:0] nxt;
    nxt = a + 21'h2;
    global_interrupt_enable <= gie_v;
    // First pass runs with brown-out off, so its ready line never rises
    brownout_enable_field <= {gie_v, gie_v};
    int_enable <= 16'h0103;
    peripheral_interrupt_enable <= 1'b0;
    {program_flash_memory_ready, current_osc_select_ready, brownout_ready} <= 3'h0;
    do_sleep(a);
    chk("prefetch_valid", prefetch_valid, 1'b1);
    chk("prefetch_pc", prefetch_pc, nxt);
    chk("watchdog_clear", watchdog_clear, 1'b1);
    chk("flags", {timeout_flag, powerdown_flag}, 2'b10);
    chk("core_clk_en", core_clk_en, 1'b0);
    // Clock-switch source and a peripheral source without its group enable
    int_flag <= 16'h0102;
    step(4);
    chk("asleep", core_clk_en, 1'b0);
    peripheral_interrupt_enable <= 1'b1;
    step(1);
    chk("wake watchdog_clear", watchdog_clear, 1'b1);
    int_flag <= 16'h0;
    for (int i = 0; i < 3; i++) begin
      chk("ready wait", {resume_exec, core_clk_en}, 2'b00);
      {program_flash_memory_ready, current_osc_select_ready, brownout_ready} <=
        (3'h7 >> (2 - i)) & {2'h3, gie_v};
      step(1);
    end
    chk("resume_exec", resume_exec, 1'b1);
    chk("vector_after_next", vector_after_next, gie_v);
    chk("device_reset_req", device_reset_req, 1'b0);
    $display("t_int_wake done");
  endtask
  task automatic t_reset_wake;
    for (int i = 0; i < 5; i++) begin
      do_sleep(21'h000200);
      {master_clear_pin, brownout_reset, low_power_brownout_reset, power_on_reset,
        watchdog_timer_event} <= 5'h10 >> i;
      step(1);
      chk("device_reset_req", device_reset_req, 1'b1);
      chk("reset watchdog_clear", watchdog_clear, 1'b1);
      {master_clear_pin, brownout_reset, low_power_brownout_reset, power_on_reset,
        watchdog_timer_event} <= 5'h0;
      step(1);
    end
    $display("t_reset_wake done");
  endtask
  task automatic t_regs;
    chk("irq masked", irq, 1'b0);
    rd(swc_pkg::ADDR_STATUS, 8'h03);
    wr(swc_pkg::ADDR_MASK, 8'h01);
    chk("irq", irq, 1'b1);
    wr(swc_pkg::ADDR_STATUS, 8'h01);
    chk("irq cleared", irq, 1'b0);
    rd(swc_pkg::ADDR_STATUS, 8'h02);
    rd(swc_pkg::ADDR_MASK, 8'h01);
    rd(4'hf, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_pending;
    flag_clear <= 1'b1;
    step(1);
    flag_clear <= 1'b0;
    global_interrupt_enable <= 1'b0;
    int_enable <= 16'h0001;
    int_flag <= 16'h0001;
    do_sleep(21'h000100);
    chk("nop core_clk_en", core_clk_en, 1'b1);
    chk("nop watchdog_clear", watchdog_clear, 1'b0);
    chk("nop flags", {timeout_flag, powerdown_flag}, 2'b11);
    int_flag <= 16'h0;
    // The aborted sleep is logged as its own status event
    rd(swc_pkg::ADDR_STATUS, 8'h06);
    wr(swc_pkg::ADDR_MASK, 8'h04);
    chk("irq nop", irq, 1'b1);
    $display("t_pending done");
  endtask
  task automatic t_gated_reset;
    do_sleep(21'h000300);
    {master_clear_enable, low_power_brownout_enable, watchdog_enable} <= 3'h0;
    {master_clear_pin, low_power_brownout_reset, watchdog_timer_event} <= 3'h7;
    step(2);
    chk("gated device_reset_req", device_reset_req, 1'b0);
    chk("gated asleep", core_clk_en, 1'b0);
    {master_clear_pin, low_power_brownout_reset, watchdog_timer_event} <= 3'h0;
    {master_clear_enable, low_power_brownout_enable, watchdog_enable} <= 3'h7;
    power_on_reset <= 1'b1;
    step(1);
    chk("por device_reset_req", device_reset_req, 1'b1);
    // A reset-class source still active refuses the next sleep
    do_sleep(21'h000300);
    chk("blocked core_clk_en", core_clk_en, 1'b1);
    chk("blocked watchdog_clear", watchdog_clear, 1'b0);
    power_on_reset <= 1'b0;
    $display("t_gated_reset done");
  endtask
  task automatic t_mid_reset;
    do_sleep(21'h000400);
    rst_n <= 1'b0;
    step(2);
    rst_n <= 1'b1;
    step(1);
    chk("mid reset flags", {timeout_flag, powerdown_flag, core_clk_en}, 3'b111);
    rd(swc_pkg::ADDR_STATUS, 8'h00);
    $display("t_mid_reset done");
  endtask
  initial begin
    {go, global_interrupt_enable, peripheral_interrupt_enable, master_clear_pin, brownout_reset,
      low_power_brownout_reset, power_on_reset, watchdog_timer_event, software_brownout_enable,
      flag_clear, reg_write, reg_read, rst_n, int_flag, int_enable, reg_addr, reg_wdata, pc} = '0;
    {clk_en, master_clear_enable, low_power_brownout_enable, watchdog_enable,
      program_flash_memory_ready, current_osc_select_ready, brownout_ready} = '1;
    brownout_enable_field = 2'h3;
    clock_switch_sel = 16'h0002;
    step(3);
    rst_n <= 1'b1;
    step(1);
    chk("reset flags", {timeout_flag, powerdown_flag, core_clk_en}, 3'b111);
    t_bor_field;
    t_int_wake(1'b0, 21'h001ffe);
    t_int_wake(1'b1, 21'h1ffffe);
    t_reset_wake;
    t_gated_reset;
    t_regs;
    t_pending;
    t_mid_reset;
    wrap_up;
  end
  // Whole run is about a hundred cycles; this only catches a hung wait
  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    wrap_up;
  end
endmodule // swc_top_test
